// file: src/sdf_pkg.sv
package sdf_pkg;
    // Decimation modes
    localparam int SDF_NORM_PERIOD     = 512;
    localparam int SDF_LOW_PERIOD      = 5120;
    localparam int SDF_NORM_UPDATE     = 170;
    localparam int SDF_LOW_UPDATE      = 1700;
    localparam int SDF_TAPS_PER_STAGE  = 171;
    localparam int SDF_TOTAL_TAPS      = 511;
    localparam int SDF_NORM_WIDTH      = 21;
    localparam int SDF_LOW_WIDTH       = 33;
    localparam int SDF_OUT_WIDTH       = 16;
    localparam int SDF_ACC_BITS        = 12;
    localparam int SDF_LOW_OUT_LSB     = 18;
    localparam int SDF_NORM_OUT_LSB    = SDF_NORM_WIDTH - SDF_OUT_WIDTH;
    localparam int SDF_CHANNELS        = 4;
    localparam int SDF_CH_BITS         = 2;
    localparam int SDF_CNT_BITS        = 13;
    localparam int SDF_SETTLE_CYCLES   = 30;
    localparam int SDF_LOW_SEL_BIT     = 14;
    typedef enum logic [0:0] {SDF_NORMAL, SDF_LOW_RATE} sdf_mode_t;
endpackage

// file: src/sdf_sync2.sv
`timescale 1ns/1ps
module sdf_sync2
#(
    parameter int W = 1
)
(
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_sync_out;

    always_comb
    begin
        next_meta     = async_in;
        next_sync_out = meta;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta     <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta     <= next_meta;
            sync_out <= next_sync_out;
        end
    end
endmodule

// file: src/sdf_sinc3_filter.sv
`timescale 1ns/1ps
// Functional notes
// - Modulator bitstream feeds a third-order sinc low-pass decimator.
// - Three moving-sum stages of 171 taps, 511 taps overall.
// - Three integrators at oversampling rate, three differentiators decimated.
// - Normal mode registers 21 bits, output keeps upper 16 bits.
// - All 16 output bits readable; top 12 are the accurate ones.
// - Decimated section updates at count 1700 low-rate, 170 normal.
// - Low-rate widens to 33 bits, output bits 33:18 of last stage.
// - Filter cleared every 5120 cycles low-rate, 512 normal.
// - One sample per 512 oversampling clocks, or 5120 low-rate.
// - Samples go to four per-channel 16-bit result registers.
// - Results are signed two's complement around the common-mode level.
// - Analog section powered down while the power control bit is clear.
// - Digital section stops through the standard clock gating.
// - First cycle of each period resets modulator and clears filter.
// - Low-rate select chooses decimation 512 or 5120.
// - Bus-clocked registers; oversampling signals double-flop synchronised.
module sdf_sinc3_filter
#(
    parameter int ACC_W = sdf_pkg::SDF_LOW_WIDTH + 1
)
(
    input  wire logic                              clk,
    input  wire logic                              sys_rst,
    input  wire logic                              mod_clk,
    input  wire logic                              mod_bit,
    input  wire logic                              low_rate_select,
    input  wire logic                              analog_enable,
    input  wire logic                              single_channel,
    input  wire logic [sdf_pkg::SDF_CH_BITS-1:0]   channel_addr,
    output logic                                   analog_power_on,
    output logic                                   modulator_reset,
    output logic [sdf_pkg::SDF_CH_BITS-1:0]        channel_sel,
    output logic [sdf_pkg::SDF_OUT_WIDTH-1:0]      sample_data,
    output logic                                   sample_valid,
    output logic [sdf_pkg::SDF_CH_BITS-1:0]        sample_channel,
    output logic [4*sdf_pkg::SDF_OUT_WIDTH-1:0]    channel_result_regs
);
    import sdf_pkg::*;

    localparam logic [SDF_CNT_BITS-1:0] NORM_LAST =
        SDF_CNT_BITS'(SDF_NORM_PERIOD - 1);
    localparam logic [SDF_CNT_BITS-1:0] LOW_LAST =
        SDF_CNT_BITS'(SDF_LOW_PERIOD - 1);
    localparam logic [SDF_CNT_BITS-1:0] NORM_UPD =
        SDF_CNT_BITS'(SDF_NORM_UPDATE);
    localparam logic [SDF_CNT_BITS-1:0] LOW_UPD =
        SDF_CNT_BITS'(SDF_LOW_UPDATE);

    ////////////////////////////////////////////////////////////////////////
    // Oversampling clock and bit are pins: two flops before use
    logic mod_clk_s;
    logic mod_bit_s;
    logic mod_clk_d;
    logic next_mod_clk_d;
    logic tick;

    sdf_sync2 #(.W(2)) u_sync
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({mod_clk, mod_bit}),
        .sync_out ({mod_clk_s, mod_bit_s})
    );

    always_comb
    begin
        next_mod_clk_d = mod_clk_s;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            mod_clk_d <= 1'b0;
        else
            mod_clk_d <= next_mod_clk_d;
    end

    // One oversampling step per rising edge of the synchronised clock
    assign tick = mod_clk_s & ~mod_clk_d;

    ////////////////////////////////////////////////////////////////////////
    // Filter datapath
    sdf_mode_t                   mode;
    logic [SDF_CNT_BITS-1:0]     cnt;
    logic [ACC_W-1:0]            integ [3];
    logic [ACC_W-1:0]            diff  [3];
    logic [ACC_W-1:0]            dly   [3];
    logic [SDF_CH_BITS-1:0]      chan;
    logic                        pwr;
    logic                        mrst;
    logic [SDF_OUT_WIDTH-1:0]    res   [SDF_CHANNELS];
    logic [SDF_OUT_WIDTH-1:0]    sdata;
    logic                        svalid;
    logic [SDF_CH_BITS-1:0]      schan;

    sdf_mode_t                   next_mode;
    logic [SDF_CNT_BITS-1:0]     next_cnt;
    logic [ACC_W-1:0]            next_integ [3];
    logic [ACC_W-1:0]            next_diff  [3];
    logic [ACC_W-1:0]            next_dly   [3];
    logic [SDF_CH_BITS-1:0]      next_chan;
    logic                        next_pwr;
    logic                        next_mrst;
    logic [SDF_OUT_WIDTH-1:0]    next_res   [SDF_CHANNELS];
    logic [SDF_OUT_WIDTH-1:0]    next_sdata;
    logic                        next_svalid;
    logic [SDF_CH_BITS-1:0]      next_schan;

    always_comb
    begin
        logic [SDF_CNT_BITS-1:0] last;
        logic [SDF_CNT_BITS-1:0] upd;
        logic [ACC_W-1:0]        in_val;
        logic [ACC_W-1:0]        stage_in;
        logic [ACC_W-1:0]        fin;
        last        = (mode == SDF_LOW_RATE) ? LOW_LAST : NORM_LAST;
        upd         = (mode == SDF_LOW_RATE) ? LOW_UPD : NORM_UPD;
        in_val      = '0;
        stage_in    = '0;
        fin         = '0;
        next_mode   = mode;
        next_cnt    = cnt;
        next_integ  = integ;
        next_diff   = diff;
        next_dly    = dly;
        next_chan   = chan;
        next_pwr    = analog_enable;
        next_mrst   = 1'b0;
        next_res    = res;
        next_sdata  = sdata;
        next_svalid = 1'b0;
        next_schan  = schan;
        if (!pwr)
        begin
            // Powered down: zero the counter so the next period starts clean
            next_cnt  = '0;
            next_mrst = 1'b1;
            next_mode = low_rate_select ? SDF_LOW_RATE : SDF_NORMAL;
        end
        else if (tick)
        begin
            if (cnt == '0)
            begin
                // Clear all filter stages on the first cycle of a period
                next_mrst = 1'b1;
                for (int i = 0; i < 3; i++)
                begin
                    next_integ[i] = '0;
                    next_diff[i]  = '0;
                    next_dly[i]   = '0;
                end
            end
            else
            begin
                // Integrators at the oversampling rate
                // Bit 1 maps to +1, bit 0 to -1, so mid-scale gives zero
                in_val = mod_bit_s ? ACC_W'(1) : '1;
                next_integ[0] = integ[0] + in_val;
                next_integ[1] = integ[1] + integ[0];
                next_integ[2] = integ[2] + integ[1];
                // Comb section steps every upd counts
                if ((cnt % upd) == '0)
                begin
                    stage_in = integ[2];
                    for (int i = 0; i < 3; i++)
                    begin
                        next_diff[i] = stage_in - dly[i];
                        next_dly[i]  = stage_in;
                        stage_in     = stage_in - dly[i];
                    end
                end
            end
            if (cnt == last)
            begin
                // Period end: one sample per channel slot
                fin = diff[2];
                if (mode == SDF_LOW_RATE)
                    next_sdata = fin[SDF_LOW_OUT_LSB +: SDF_OUT_WIDTH];
                else
                    next_sdata = fin[SDF_NORM_OUT_LSB +: SDF_OUT_WIDTH];
                next_svalid     = 1'b1;
                next_schan      = chan;
                next_res[chan]  = next_sdata;
                next_chan       = single_channel ? channel_addr : chan + 1'b1;
                next_cnt        = '0;
                // Mode change is only taken at period end or while powered down
                next_mode = low_rate_select ? SDF_LOW_RATE : SDF_NORMAL;
            end
            else
            begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            mode   <= SDF_NORMAL;
            cnt    <= '0;
            chan   <= '0;
            pwr    <= 1'b0;
            mrst   <= 1'b1;
            sdata  <= '0;
            svalid <= 1'b0;
            schan  <= '0;
            for (int i = 0; i < 3; i++)
            begin
                integ[i] <= '0;
                diff[i]  <= '0;
                dly[i]   <= '0;
            end
            for (int i = 0; i < SDF_CHANNELS; i++)
                res[i] <= '0;
        end
        else
        begin
            mode   <= next_mode;
            cnt    <= next_cnt;
            integ  <= next_integ;
            diff   <= next_diff;
            dly    <= next_dly;
            chan   <= next_chan;
            pwr    <= next_pwr;
            mrst   <= next_mrst;
            res    <= next_res;
            sdata  <= next_sdata;
            svalid <= next_svalid;
            schan  <= next_schan;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops; clock gating is outside
    genvar g;
    generate
        for (g = 0; g < SDF_CHANNELS; g++)
        begin : g_res
            assign channel_result_regs[g*SDF_OUT_WIDTH +: SDF_OUT_WIDTH] =
                res[g];
        end
    endgenerate

    assign analog_power_on = pwr;
    assign modulator_reset = mrst;
    assign channel_sel     = chan;
    assign sample_data     = sdata;
    assign sample_valid    = svalid;
    assign sample_channel  = schan;
endmodule

// file: sim/sdf_sinc3_filter_asserts.sv
`timescale 1ns/1ps
module sdf_sinc3_filter_asserts
(
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        mod_clk,
    input wire logic        mod_bit,
    input wire logic        low_rate_select,
    input wire logic        analog_enable,
    input wire logic        single_channel,
    input wire logic [1:0]  channel_addr,
    input wire logic        analog_power_on,
    input wire logic        modulator_reset,
    input wire logic [1:0]  channel_sel,
    input wire logic [15:0] sample_data,
    input wire logic        sample_valid,
    input wire logic [1:0]  sample_channel,
    input wire logic [63:0] channel_result_regs
);
    logic [2:0]  sy;
    logic [12:0] n_tk;
    logic        armed;
    logic        lrs_q;
    wire         tick = sy[1] & ~sy[2];

    // Ticks between samples; a mode or power change spoils the count
    always_ff @(posedge clk)
    begin
        sy    <= {sy[1:0], mod_clk};
        lrs_q <= low_rate_select;
        n_tk  <= sample_valid ? {12'h0, tick} : n_tk + {12'h0, tick};
        if (sys_rst || !analog_power_on || low_rate_select != lrs_q)
            armed <= 1'b0;
        else
            armed <= sample_valid | armed;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////
    AST_OFF_NO_SAMPLE: assert property
        ((!analog_power_on)[*3] |-> !sample_valid)
        else $error("sample while off");
    AST_OFF_MOD_RESET: assert property
        (!analog_power_on && !$past(analog_power_on) |-> modulator_reset)
        else $error("no reset while off");
    AST_VALID_ONE: assert property
        (sample_valid |=> !sample_valid)
        else $error("valid too long");
    AST_RESULT_MATCH: assert property
        (sample_valid |->
            channel_result_regs[sample_channel*16 +: 16] == sample_data)
        else $error("result slot wrong");
    AST_HOLD_DATA: assert property
        (!sample_valid |-> $stable(sample_data) && $stable(sample_channel))
        else $error("sample moved");
    AST_HOLD_RESULTS: assert property
        (!sample_valid |-> $stable(channel_result_regs))
        else $error("results moved");
    AST_PERIOD: assert property
        (sample_valid && armed |-> n_tk == (lrs_q ? 13'd5120 : 13'd512))
        else $error("period wrong");
    // Channel choice was made one cycle before the strobe
    AST_RR_NEXT: assert property
        (sample_valid && !$past(single_channel) |->
            channel_sel == sample_channel + 2'h1)
        else $error("channel not advanced");
    // While running, the clear pulse lasts one cycle only
    AST_RUN_RESET_ONE: assert property
        (analog_power_on && $past(analog_power_on) && modulator_reset |=>
            !modulator_reset)
        else $error("reset pulse too long");
endmodule

bind sdf_sinc3_filter sdf_sinc3_filter_asserts i_sdf_sinc3_filter_asserts
(
    .clk(clk), .sys_rst(sys_rst), .mod_clk(mod_clk), .mod_bit(mod_bit),
    .low_rate_select(low_rate_select), .analog_enable(analog_enable),
    .single_channel(single_channel), .channel_addr(channel_addr),
    .analog_power_on(analog_power_on), .modulator_reset(modulator_reset),
    .channel_sel(channel_sel), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_channel(sample_channel),
    .channel_result_regs(channel_result_regs)
);

// file: sim/sdf_mod_model.sv
`timescale 1ns/1ps
module sdf_mod_model
#(
    parameter real HALF_NS = 62.5
)
(
    output logic            mod_clk,
    output logic            mod_bit,
    input  wire logic [7:0] density
);
    logic [7:0] acc;

    // Runs free like a prescaler output; offset keeps edges off clk edges
    initial
    begin
        mod_clk = 1'b0;
        mod_bit = 1'b0;
        acc     = 8'h0;
        #3;
        forever
        begin
            #(HALF_NS) mod_clk = ~mod_clk;
            if (!mod_clk)
                {mod_bit, acc} = {1'b0, acc} + {1'b0, density};
        end
    end
endmodule

// file: sim/sdf_sinc3_filter_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sdf_sinc3_filter_tb;
    import sdf_pkg::*;
    logic        clk, sys_rst, mod_clk, mod_bit, low_rate_select;
    logic        analog_enable, single_channel, analog_power_on;
    logic        modulator_reset, sample_valid;
    logic [1:0]  channel_addr, channel_sel, sample_channel;
    logic [15:0] sample_data;
    logic [63:0] channel_result_regs;
    logic [7:0]  density;
    int          bad_count, n_tests, cyc, g;
    logic signed [15:0] sd;
    time         t_last;

    sdf_mod_model i_sdf_mod_model (.mod_clk(mod_clk), .mod_bit(mod_bit),
        .density(density));
    sdf_sinc3_filter i_sdf_sinc3_filter (.clk(clk), .sys_rst(sys_rst),
        .mod_clk(mod_clk), .mod_bit(mod_bit),
        .low_rate_select(low_rate_select), .analog_enable(analog_enable),
        .single_channel(single_channel), .channel_addr(channel_addr),
        .analog_power_on(analog_power_on),
        .modulator_reset(modulator_reset), .channel_sel(channel_sel),
        .sample_data(sample_data), .sample_valid(sample_valid),
        .sample_channel(sample_channel),
        .channel_result_regs(channel_result_regs));
    ////////////////////////////////////////////////////////////////////
    task stop_test;
        if (bad_count == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Gap since the previous sample, in clk cycles
    task automatic wait_sample;
        int k;
        k = 0;
        do
        begin
            @(posedge clk);
            #1;
            k++;
        end
        while (sample_valid !== 1'b1 && k < 60000);
        g = int'(($time - t_last) / 25);
        t_last = $time;
    endtask

    task automatic test_off;
        int seen;
        seen = 0;
        // Unknown strobe counts as a sample so it cannot slip through
        repeat (200)
        begin
            @(posedge clk);
            #1;
            if (sample_valid !== 1'b0)
                seen++;
        end
        `CHK(seen, 0)
        `CHK(modulator_reset, 1'b1)
        `CHK(channel_result_regs, 64'h0)
    endtask

    task automatic test_rr;
        logic [1:0] ch;
        @(posedge clk) analog_enable <= 1'b1;
        wait_sample();
        ch = sample_channel;
        repeat (4)
        begin
            wait_sample();
            sd = sample_data;
            `CHK(sample_channel, ch + 2'h1)
            `CHK(g, 2560)
            `CHK(sd < 16 && sd > -16, 1'b1)
            ch = sample_channel;
        end
    endtask

    task automatic test_single;
        @(posedge clk) single_channel <= 1'b1;
        channel_addr <= 2'h2;
        density <= 8'd136;
        wait_sample();
        wait_sample();
        `CHK(sample_channel, 2'h2)
        `CHK(sample_data[15], 1'b0)
        `CHK(sample_data != 16'h0, 1'b1)
    endtask

    // Mode changed while powered off, so the next period is low-rate
    task automatic test_low;
        @(posedge clk) analog_enable <= 1'b0;
        low_rate_select <= 1'b1;
        density <= 8'd120;
        repeat (10) @(posedge clk);
        analog_enable <= 1'b1;
        wait_sample();
        wait_sample();
        `CHK(g, 25600)
        `CHK(sample_data[15], 1'b1)
        `CHK(channel_result_regs[47:32], sample_data)
    endtask

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc > 90000)
        begin
            bad_count++;
            stop_test();
        end
    end

    initial
    begin
        sys_rst = 1'b1;
        low_rate_select = 1'b0;
        analog_enable = 1'b0;
        single_channel = 1'b0;
        channel_addr = 2'h0;
        density = 8'd128;
        t_last = 0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        test_off();
        test_rr();
        test_single();
        test_low();
        stop_test();
    end
endmodule
